/* hdl/charger_cfg.svh */
// Purpose: constants of the charge state controller
// Assumes: 200 MHz system clock
// Notes: option codes select ratios and regulation voltage
`ifndef CHARGER_CFG_SVH
`define CHARGER_CFG_SVH

// ***************************************************************
// timing
// ***************************************************************
`define CLK_PERIOD_PS 5000
`define TERM_FILTER_MS 1
`define TERM_FILTER_CYC ((`TERM_FILTER_MS * 1000000000) / `CLK_PERIOD_PS)

// ***************************************************************
// comparator vector layout
// ***************************************************************
`define CMP_W 16
`define CMP_SUPPLY_OK 0
`define CMP_SUPPLY_HYST_OK 1
`define CMP_MARGIN_OK 2
`define CMP_NEAR_BAT 3
`define CMP_BAT_ABSENT 4
`define CMP_BELOW_PRECOND 5
`define CMP_AT_REG 6
`define CMP_BELOW_TERM 7
`define CMP_BELOW_RECHARGE 8
`define CMP_DIE_HOT 9
`define CMP_DIE_COOLED 10
`define CMP_SET_PIN_EN 11
`define CMP_DERATE_LO 12
`define CMP_DERATE_HI 15

// ***************************************************************
// ratios in per mille of programmed current, derating in sixteenths, voltages in mV
// ***************************************************************
`define FULL_PERMILLE 11'h03e8
`define TRICKLE_PM_0 11'h0064
`define TRICKLE_PM_1 11'h00c8
`define TRICKLE_PM_2 11'h0190
`define TERM_PM_0 11'h0032
`define TERM_PM_1 11'h004b
`define TERM_PM_2 11'h0064
`define TERM_PM_3 11'h00c8
`define REG_MV_0 13'h1068
`define REG_MV_1 13'h10fe
`define REG_MV_2 13'h1130
`define REG_MV_3 13'h1194
`define DERATE_FULL 5'h10
`define DERATE_SHIFT 4

`endif

/* hdl/charger_pkg.sv */
// Purpose: types of the charge state controller
// Assumes: nothing
// Notes: state codes are fixed binary
package charger_pkg;
	typedef enum logic [2:0] {
		ST_SHUTDOWN = 3'b000,
		ST_NO_BATTERY = 3'b001,
		ST_TRICKLE = 3'b010,
		ST_FAST_CC = 3'b011,
		ST_CONST_V = 3'b100,
		ST_COMPLETE = 3'b101
	} charge_state_t;
endpackage

/* hdl/cmp_sync_if.sv */
// Purpose: raw and synchronised comparator results
// Assumes: one clock domain on the clean side
// Notes: width set by the instantiating module
`timescale 1ns/100ps
interface cmp_sync_if #(parameter int W = 16);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface

/* hdl/cmp_sync.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: asynchronous comparator levels
// Notes: clean changes only when stages two and three agree
`timescale 1ns/100ps
module cmp_sync #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// comparator levels
	cmp_sync_if.sync port
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] clean_d;
	logic [W-1:0] clean_q;

	// ***************************************************************
	// per-bit filter
	// ***************************************************************
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_comb
			begin
				clean_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : clean_q[i];
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			clean_q <= '0;
		end
		else
		begin
			s1_q <= port.raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			clean_q <= clean_d;
		end
	end

	assign port.clean = clean_q;
endmodule // cmp_sync

/* hdl/charge_ctrl.sv */
// Purpose: charge sequencing of a single-cell lithium charger
// Assumes: analog comparators deliver the levels below
// Notes: current loop and pass device are outside this block
//
// Contract
// - supply below lockout threshold holds shutdown, release needs 100 mV more.
// - leave shutdown only with supply 150 mV above battery, when attached.
// - supply within 50 mV of battery forces shutdown.
// - lockout is checked in every state.
// - battery absent when its voltage reaches regulation plus 100 mV.
// - charging starts only with lockout clear, battery present, pin enabled.
// - open set pin disables; outside party may use it as enable.
// - below precondition threshold charge in trickle at a fraction; TRICKLE_OPTION 3 gives full current (1000 per mille).
// - above precondition threshold move to constant current.
// - constant current until regulation voltage, then constant voltage.
// - regulation voltage is one of 4.2, 4.35, 4.40, 4.50 V.
// - terminate in constant voltage on low current filtered 1 ms.
// - on termination latch current off and enter complete.
// - in complete, recharge when battery drops below recharge threshold.
// - reduce permitted current with die temperature.
// - suspend above 150 C die, resume after about 10 C cooling.
// - status floats in shutdown and no battery, low while charging.
// - in complete tri-state drives high, open-drain floats.
// - trickle and termination currents are ratios of programmed current.
// - complete holds until enable cycles or battery drops below recharge threshold; dropping enable ends charge.
`timescale 1ns/100ps
`include "charger_cfg.svh"
module charge_ctrl #(
	parameter int TERM_FILTER_CYCLES = `TERM_FILTER_CYC,
	parameter logic [1:0] REG_OPTION = 2'h0,
	parameter logic [1:0] TRICKLE_OPTION = 2'h0,
	parameter logic [1:0] TERM_OPTION = 2'h2,
	parameter bit OPEN_DRAIN = 1'b0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// supply comparators
	input wire logic supply_lockout_ok,
	input wire logic supply_lockout_hyst_ok,
	input wire logic supply_margin_ok,
	input wire logic supply_near_battery,
	// battery comparators
	input wire logic battery_absent,
	input wire logic battery_below_precond,
	input wire logic battery_at_regulation,
	input wire logic battery_below_recharge,
	input wire logic current_below_term,
	// thermal comparators
	input wire logic die_over_limit,
	input wire logic die_cooled,
	input wire logic [3:0] die_derate_level,
	// program pin
	input wire logic current_set_pin_en,
	// charge control
	output logic charge_on,
	output logic cv_mode,
	output logic [10:0] current_permille,
	output logic [10:0] term_permille,
	output logic [12:0] regulation_voltage_mv,
	output charger_pkg::charge_state_t charge_phase,
	output logic thermal_hold,
	// status pin
	output logic status_out,
	output logic status_oe
);
	localparam int CNT_W = $clog2(TERM_FILTER_CYCLES + 1);
	localparam logic [CNT_W-1:0] TERM_LAST =
		CNT_W'(TERM_FILTER_CYCLES - 1);

	// ***************************************************************
	// input synchronisation
	// ***************************************************************
	cmp_sync_if #(.W(`CMP_W)) cmp ();

	assign cmp.raw = {die_derate_level, current_set_pin_en, die_cooled,
		die_over_limit, battery_below_recharge, current_below_term,
		battery_at_regulation, battery_below_precond, battery_absent,
		supply_near_battery, supply_margin_ok, supply_lockout_hyst_ok,
		supply_lockout_ok};

	cmp_sync #(.W(`CMP_W)) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.port(cmp.sync)
	);

	logic lock_ok;
	logic lock_hyst_ok;
	logic margin_ok;
	logic near_bat;
	logic absent;
	logic below_pre;
	logic at_reg;
	logic below_term;
	logic below_rech;
	logic die_hot;
	logic cooled;
	logic pin_en;
	logic [3:0] derate;

	assign lock_ok = cmp.clean[`CMP_SUPPLY_OK];
	assign lock_hyst_ok = cmp.clean[`CMP_SUPPLY_HYST_OK];
	assign margin_ok = cmp.clean[`CMP_MARGIN_OK];
	assign near_bat = cmp.clean[`CMP_NEAR_BAT];
	assign absent = cmp.clean[`CMP_BAT_ABSENT];
	assign below_pre = cmp.clean[`CMP_BELOW_PRECOND];
	assign at_reg = cmp.clean[`CMP_AT_REG];
	assign below_term = cmp.clean[`CMP_BELOW_TERM];
	assign below_rech = cmp.clean[`CMP_BELOW_RECHARGE];
	assign die_hot = cmp.clean[`CMP_DIE_HOT];
	assign cooled = cmp.clean[`CMP_DIE_COOLED];
	assign pin_en = cmp.clean[`CMP_SET_PIN_EN];
	assign derate = cmp.clean[`CMP_DERATE_HI:`CMP_DERATE_LO];

	// ***************************************************************
	// option decode
	// ***************************************************************
	function automatic logic [10:0] trickle_pm(input logic [1:0] opt);
		case (opt)
			2'h0: trickle_pm = `TRICKLE_PM_0;
			2'h1: trickle_pm = `TRICKLE_PM_1;
			2'h2: trickle_pm = `TRICKLE_PM_2;
			default: trickle_pm = `FULL_PERMILLE;
		endcase
	endfunction

	function automatic logic [10:0] term_pm(input logic [1:0] opt);
		case (opt)
			2'h0: term_pm = `TERM_PM_0;
			2'h1: term_pm = `TERM_PM_1;
			2'h2: term_pm = `TERM_PM_2;
			default: term_pm = `TERM_PM_3;
		endcase
	endfunction

	function automatic logic [12:0] reg_mv(input logic [1:0] opt);
		case (opt)
			2'h0: reg_mv = `REG_MV_0;
			2'h1: reg_mv = `REG_MV_1;
			2'h2: reg_mv = `REG_MV_2;
			default: reg_mv = `REG_MV_3;
		endcase
	endfunction

	function automatic logic charging(input charger_pkg::charge_state_t s);
		charging = (s == charger_pkg::ST_TRICKLE) ||
			(s == charger_pkg::ST_FAST_CC) ||
			(s == charger_pkg::ST_CONST_V);
	endfunction

	// ***************************************************************
	// lockout, thermal hold, termination filter
	// ***************************************************************
	logic lockout_d;
	logic lockout_q;
	logic hot_d;
	logic hot_q;
	logic [CNT_W-1:0] term_cnt_d;
	logic [CNT_W-1:0] term_cnt_q;
	logic term_done;
	charger_pkg::charge_state_t state_d;
	charger_pkg::charge_state_t state_q;

	always_comb
	begin
		lockout_d = lockout_q;
		// entry uses the plain threshold, exit the raised one
		if (!lock_ok || near_bat)
			lockout_d = 1'b1;
		else if (lock_hyst_ok && (margin_ok || absent))
			lockout_d = 1'b0;
		// overtemperature set wins over cooling
		hot_d = hot_q;
		if (die_hot)
			hot_d = 1'b1;
		else if (cooled)
			hot_d = 1'b0;
		// any gap in low current restarts the filter
		term_cnt_d = '0;
		if (state_q == charger_pkg::ST_CONST_V && below_term &&
			term_cnt_q != TERM_LAST)
			term_cnt_d = term_cnt_q + 1'b1;
	end

	assign term_done = (state_q == charger_pkg::ST_CONST_V) && below_term &&
		(term_cnt_q == TERM_LAST);

	// ***************************************************************
	// charge sequence
	// ***************************************************************
	always_comb
	begin
		state_d = state_q;
		if (lockout_q || !pin_en)
			state_d = charger_pkg::ST_SHUTDOWN;
		else
		begin
			case (state_q)
				charger_pkg::ST_SHUTDOWN,
				charger_pkg::ST_NO_BATTERY:
					if (absent)
						state_d = charger_pkg::ST_NO_BATTERY;
					else if (below_pre)
						state_d = charger_pkg::ST_TRICKLE;
					else
						state_d = charger_pkg::ST_FAST_CC;
				charger_pkg::ST_TRICKLE:
					if (absent)
						state_d = charger_pkg::ST_NO_BATTERY;
					else if (!below_pre)
						state_d = charger_pkg::ST_FAST_CC;
				charger_pkg::ST_FAST_CC:
					if (absent)
						state_d = charger_pkg::ST_NO_BATTERY;
					else if (at_reg)
						state_d = charger_pkg::ST_CONST_V;
				charger_pkg::ST_CONST_V:
					if (absent)
						state_d = charger_pkg::ST_NO_BATTERY;
					else if (term_done)
						state_d = charger_pkg::ST_COMPLETE;
				charger_pkg::ST_COMPLETE:
					if (absent)
						state_d = charger_pkg::ST_NO_BATTERY;
					else if (below_rech)
						state_d = below_pre ? charger_pkg::ST_TRICKLE :
							charger_pkg::ST_FAST_CC;
				default:
					state_d = charger_pkg::ST_SHUTDOWN;
			endcase
		end
	end

	// ***************************************************************
	// outputs, computed from next state so they align with it
	// ***************************************************************
	logic charge_on_d;
	logic cv_mode_d;
	logic [10:0] current_d;
	logic [15:0] scaled;
	logic status_out_d;
	logic status_oe_d;

	always_comb
	begin
		charge_on_d = charging(state_d) && !hot_d;
		cv_mode_d = (state_d == charger_pkg::ST_CONST_V);
		current_d = '0;
		if (state_d == charger_pkg::ST_TRICKLE)
			current_d = trickle_pm(TRICKLE_OPTION);
		else if (charging(state_d))
			current_d = `FULL_PERMILLE;
		// derating trades charge time against die heating
		scaled = 16'(current_d * (`DERATE_FULL - {1'b0, derate}));
		if (!charge_on_d)
			current_d = '0;
		else
			current_d = 11'(scaled >> `DERATE_SHIFT);
		status_out_d = 1'b0;
		status_oe_d = 1'b0;
		if (charging(state_d))
			status_oe_d = 1'b1;
		else if (state_d == charger_pkg::ST_COMPLETE && !OPEN_DRAIN)
		begin
			status_out_d = 1'b1;
			status_oe_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= charger_pkg::ST_SHUTDOWN;
			lockout_q <= 1'b1;
			hot_q <= 1'b0;
			term_cnt_q <= '0;
			charge_on <= 1'b0;
			cv_mode <= 1'b0;
			current_permille <= '0;
			status_out <= 1'b0;
			status_oe <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			lockout_q <= lockout_d;
			hot_q <= hot_d;
			term_cnt_q <= term_cnt_d;
			charge_on <= charge_on_d;
			cv_mode <= cv_mode_d;
			current_permille <= current_d;
			status_out <= status_out_d;
			status_oe <= status_oe_d;
		end
	end

	assign charge_phase = state_q;
	assign thermal_hold = hot_q;
	assign term_permille = term_pm(TERM_OPTION);
	assign regulation_voltage_mv = reg_mv(REG_OPTION);

	// ***************************************************************
	// checks
	// ***************************************************************
	property p_lock_shutdown;
		@(posedge sys_clk) disable iff (!rst_n)
		lockout_q |=> state_q == charger_pkg::ST_SHUTDOWN && !charge_on;
	endproperty
	a_lock_shutdown: assert property (p_lock_shutdown)
		else $error("lockout did not force shutdown");

	property p_near_bat;
		@(posedge sys_clk) disable iff (!rst_n)
		near_bat |=> lockout_q ##1 state_q == charger_pkg::ST_SHUTDOWN;
	endproperty
	a_near_bat: assert property (p_near_bat)
		else $error("supply near battery did not lock out");

	property p_release_margin;
		@(posedge sys_clk) disable iff (!rst_n)
		$fell(lockout_q) |-> $past(lock_hyst_ok) && ($past(margin_ok) || $past(absent));
	endproperty
	a_release_margin: assert property (p_release_margin)
		else $error("lockout released without supply margin");

	property p_hysteresis;
		@(posedge sys_clk) disable iff (!rst_n)
		lockout_q && !lock_hyst_ok |=> lockout_q;
	endproperty
	a_hysteresis: assert property (p_hysteresis)
		else $error("lockout released below raised threshold");

	property p_pin_disable;
		@(posedge sys_clk) disable iff (!rst_n)
		!pin_en |=> state_q == charger_pkg::ST_SHUTDOWN && !status_oe;
	endproperty
	a_pin_disable: assert property (p_pin_disable)
		else $error("open set pin did not disable");

	property p_term_filter;
		@(posedge sys_clk) disable iff (!rst_n)
		state_q == charger_pkg::ST_COMPLETE &&
		$past(state_q) == charger_pkg::ST_CONST_V |->
		$past(term_cnt_q) == TERM_LAST && $past(below_term);
	endproperty
	a_term_filter: assert property (p_term_filter)
		else $error("termination before filter time");

	property p_status_low;
		@(posedge sys_clk) disable iff (!rst_n)
		charging(state_q) |-> status_oe && !status_out;
	endproperty
	a_status_low: assert property (p_status_low)
		else $error("status not low while charging");

	property p_status_done;
		@(posedge sys_clk) disable iff (!rst_n)
		state_q == charger_pkg::ST_COMPLETE |->
		status_oe == !OPEN_DRAIN && status_out == !OPEN_DRAIN;
	endproperty
	a_status_done: assert property (p_status_done)
		else $error("status wrong in complete");

	property p_thermal;
		@(posedge sys_clk) disable iff (!rst_n)
		die_hot |=> hot_q && !charge_on && current_permille == '0;
	endproperty
	a_thermal: assert property (p_thermal)
		else $error("charge not suspended when hot");

	property p_recharge;
		@(posedge sys_clk) disable iff (!rst_n)
		state_q == charger_pkg::ST_COMPLETE && below_rech && !absent &&
		!lockout_q && pin_en |=> charging(state_q);
	endproperty
	a_recharge: assert property (p_recharge)
		else $error("recharge did not start");
endmodule // charge_ctrl

/* testbench/status_host_model.sv */
// Purpose: host side of the status pin and the set pin
// Assumes: pull-up on the status line, as a host input would have
// Notes: the host gates charging through the set pin enable
`timescale 1ns/100ps
module status_host_model (
	// status pin
	input wire logic status_out,
	input wire logic status_oe,
	// host request
	input wire logic want_charge,
	// resolved lines
	output logic stat_line,
	output logic current_set_pin_en
);
	// released line floats up, never keeps the last driven value
	assign stat_line = status_oe ? status_out : 1'b1;
	// host opens the set pin to stop charging
	assign current_set_pin_en = want_charge;
endmodule // status_host_model

/* testbench/liion_charge_state_controller_bench.sv */
// Purpose: self-checking bench of the charge state controller
// Assumes: termination filter shortened to 8 cycles
// Notes: second instance covers open-drain and other factory options
`timescale 1ns/100ps
`include "charger_cfg.svh"
module liion_charge_state_controller_bench;
	logic sys_clk;
	logic rst_n;
	logic sup_ok, hyst_ok, margin_ok, near_bat, absent, below_pre;
	logic at_reg, below_rech, below_term, hot, cooled, want, pin_en;
	logic [3:0] derate;
	logic charge_on, cv_mode, thermal_hold, st_out, st_oe, line;
	logic od_out, od_oe, od_on, od_cv, od_hold;
	logic [10:0] cur, term_pm, od_cur, od_term;
	logic [12:0] reg_mv, od_mv;
	charger_pkg::charge_state_t phase, od_phase;
	int err_count;
	int n_compared;

	always #2.5 sys_clk = ~sys_clk;

	charge_ctrl #(.TERM_FILTER_CYCLES(8)) i_charge_ctrl (
		.sys_clk(sys_clk), .rst_n(rst_n),
		.supply_lockout_ok(sup_ok), .supply_lockout_hyst_ok(hyst_ok),
		.supply_margin_ok(margin_ok), .supply_near_battery(near_bat),
		.battery_absent(absent), .battery_below_precond(below_pre),
		.battery_at_regulation(at_reg), .battery_below_recharge(below_rech),
		.current_below_term(below_term), .die_over_limit(hot),
		.die_cooled(cooled), .die_derate_level(derate),
		.current_set_pin_en(pin_en), .charge_on(charge_on),
		.cv_mode(cv_mode), .current_permille(cur), .term_permille(term_pm),
		.regulation_voltage_mv(reg_mv), .charge_phase(phase),
		.thermal_hold(thermal_hold), .status_out(st_out), .status_oe(st_oe)
	);

	charge_ctrl #(.TERM_FILTER_CYCLES(8), .REG_OPTION(2'h3),
		.TRICKLE_OPTION(2'h1), .TERM_OPTION(2'h0), .OPEN_DRAIN(1'b1))
	i_charge_ctrl_od (
		.sys_clk(sys_clk), .rst_n(rst_n),
		.supply_lockout_ok(sup_ok), .supply_lockout_hyst_ok(hyst_ok),
		.supply_margin_ok(margin_ok), .supply_near_battery(near_bat),
		.battery_absent(absent), .battery_below_precond(below_pre),
		.battery_at_regulation(at_reg), .battery_below_recharge(below_rech),
		.current_below_term(below_term), .die_over_limit(hot),
		.die_cooled(cooled), .die_derate_level(derate),
		.current_set_pin_en(pin_en), .charge_on(od_on), .cv_mode(od_cv),
		.current_permille(od_cur), .term_permille(od_term),
		.regulation_voltage_mv(od_mv), .charge_phase(od_phase),
		.thermal_hold(od_hold), .status_out(od_out), .status_oe(od_oe)
	);

	status_host_model i_status_host_model (
		.status_out(st_out), .status_oe(st_oe), .want_charge(want),
		.stat_line(line), .current_set_pin_en(pin_en)
	);

	// ***************************************************************
	// compare and wait helpers
	// ***************************************************************
	task automatic complete_run();
		if (err_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic fail(input string msg);
		err_count++;
		$display("[FAIL] %0t %s", $time, msg);
	endtask

	task automatic check_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp)
			fail("flag mismatch");
	endtask

	task automatic check_num(input logic [12:0] got, input logic [12:0] exp);
		n_compared++;
		if (got !== exp)
			fail("value mismatch");
	endtask

	task automatic check_phase(input charger_pkg::charge_state_t exp);
		n_compared++;
		if (phase !== exp)
			fail("phase mismatch");
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// negative check: phase must not move for n cycles
	task automatic hold_phase(input charger_pkg::charge_state_t e, input int n);
		repeat (n)
		begin
			ticks(1);
			check_phase(e);
		end
	endtask

	task automatic wait_phase(input charger_pkg::charge_state_t e);
		int n;
		n = 0;
		while (phase !== e && n < 20)
		begin
			ticks(1);
			n++;
		end
		check_phase(e);
		if (phase !== e)
		begin
			fail("wait timed out");
			complete_run();
		end
	endtask

	// ***************************************************************
	// scenarios
	// ***************************************************************
	task automatic t_qualify();
		hold_phase(charger_pkg::ST_SHUTDOWN, 10);
		@(posedge sys_clk) sup_ok <= 1'b1;
		hold_phase(charger_pkg::ST_SHUTDOWN, 10);
		@(posedge sys_clk) hyst_ok <= 1'b1;
		hold_phase(charger_pkg::ST_SHUTDOWN, 10);
		@(posedge sys_clk) margin_ok <= 1'b1;
		wait_phase(charger_pkg::ST_TRICKLE);
		check_bit(st_oe, 1'b1);
		check_bit(line, 1'b0);
		check_num(13'(cur), 13'(`TRICKLE_PM_0));
		check_num(13'(od_cur), 13'(`TRICKLE_PM_1));
		check_bit(od_oe & ~od_out, 1'b1);
		@(posedge sys_clk) derate <= 4'h8;
		ticks(8);
		check_num(13'(cur), 13'(`TRICKLE_PM_0 / 2));
	endtask

	task automatic t_fast_cv();
		@(posedge sys_clk) derate <= 4'h0;
		below_pre <= 1'b0;
		wait_phase(charger_pkg::ST_FAST_CC);
		ticks(2);
		check_num(13'(cur), 13'(`FULL_PERMILLE));
		check_bit(cv_mode, 1'b0);
		@(posedge sys_clk) at_reg <= 1'b1;
		wait_phase(charger_pkg::ST_CONST_V);
		check_bit(cv_mode, 1'b1);
		check_bit(od_cv, 1'b1);
	endtask

	task automatic t_terminate();
		@(posedge sys_clk) below_term <= 1'b1;
		ticks(4);
		@(posedge sys_clk) below_term <= 1'b0;
		hold_phase(charger_pkg::ST_CONST_V, 16);
		@(posedge sys_clk) below_term <= 1'b1;
		hold_phase(charger_pkg::ST_CONST_V, 8);
		wait_phase(charger_pkg::ST_COMPLETE);
		ticks(1);
		check_bit(charge_on, 1'b0);
		check_bit(st_oe & line, 1'b1);
		check_bit(od_oe, 1'b0);
		check_bit(od_on, 1'b0);
		check_num(13'(od_phase), 13'(charger_pkg::ST_COMPLETE));
		hold_phase(charger_pkg::ST_COMPLETE, 10);
	endtask

	task automatic t_recharge();
		@(posedge sys_clk) at_reg <= 1'b0;
		below_term <= 1'b0;
		below_rech <= 1'b1;
		wait_phase(charger_pkg::ST_FAST_CC);
		ticks(2);
		check_bit(charge_on, 1'b1);
		@(posedge sys_clk) below_rech <= 1'b0;
	endtask

	task automatic t_pin_cycle();
		@(posedge sys_clk) at_reg <= 1'b1;
		below_term <= 1'b1;
		wait_phase(charger_pkg::ST_COMPLETE);
		@(posedge sys_clk) want <= 1'b0;
		wait_phase(charger_pkg::ST_SHUTDOWN);
		ticks(1);
		check_bit(st_oe, 1'b0);
		@(posedge sys_clk) at_reg <= 1'b0;
		below_term <= 1'b0;
		hold_phase(charger_pkg::ST_SHUTDOWN, 10);
		@(posedge sys_clk) want <= 1'b1;
		wait_phase(charger_pkg::ST_FAST_CC);
	endtask

	task automatic t_thermal();
		@(posedge sys_clk) hot <= 1'b1;
		cooled <= 1'b0;
		ticks(8);
		check_bit(thermal_hold, 1'b1);
		check_bit(charge_on, 1'b0);
		check_bit(od_hold, 1'b1);
		check_phase(charger_pkg::ST_FAST_CC);
		@(posedge sys_clk) hot <= 1'b0;
		ticks(8);
		check_bit(thermal_hold, 1'b1);
		@(posedge sys_clk) cooled <= 1'b1;
		ticks(8);
		check_bit(thermal_hold, 1'b0);
		check_bit(charge_on, 1'b1);
	endtask

	task automatic t_supply();
		@(posedge sys_clk) near_bat <= 1'b1;
		margin_ok <= 1'b0;
		wait_phase(charger_pkg::ST_SHUTDOWN);
		@(posedge sys_clk) near_bat <= 1'b0;
		hold_phase(charger_pkg::ST_SHUTDOWN, 10);
		@(posedge sys_clk) margin_ok <= 1'b1;
		wait_phase(charger_pkg::ST_FAST_CC);
		@(posedge sys_clk) sup_ok <= 1'b0;
		wait_phase(charger_pkg::ST_SHUTDOWN);
		@(posedge sys_clk) sup_ok <= 1'b1;
		wait_phase(charger_pkg::ST_FAST_CC);
		@(posedge sys_clk) absent <= 1'b1;
		wait_phase(charger_pkg::ST_NO_BATTERY);
		ticks(1);
		check_bit(st_oe, 1'b0);
		@(posedge sys_clk) absent <= 1'b0;
		wait_phase(charger_pkg::ST_FAST_CC);
	endtask

	// ***************************************************************
	// main sequence
	// ***************************************************************
	initial
	begin
		err_count = 0;
		n_compared = 0;
		sys_clk = 1'b0;
		rst_n = 1'b0;
		{sup_ok, hyst_ok, margin_ok, near_bat, absent} = 5'h00;
		{at_reg, below_rech, below_term, hot} = 4'h0;
		below_pre = 1'b1;
		cooled = 1'b1;
		want = 1'b1;
		derate = 4'h0;
		ticks(20);
		check_phase(charger_pkg::ST_SHUTDOWN);
		check_bit(charge_on | st_oe, 1'b0);
		check_num(reg_mv, `REG_MV_0);
		check_num(od_mv, `REG_MV_3);
		check_num(13'(term_pm), 13'(`TERM_PM_2));
		check_num(13'(od_term), 13'(`TERM_PM_0));
		@(posedge sys_clk) rst_n <= 1'b1;
		t_qualify();
		t_fast_cv();
		t_terminate();
		t_recharge();
		t_pin_cycle();
		t_thermal();
		t_supply();
		complete_run();
	end
endmodule // liion_charge_state_controller_bench
